/* inc/dsp_map_params.svh */
// Constants for the processor memory map decoder
`ifndef DSP_MAP_PARAMS_SVH
`define DSP_MAP_PARAMS_SVH
`define REG_CONFIG        12'h000
`define REG_PAGE          12'h004
`define REG_STATUS        12'h008
`define CFG_ENABLE_BIT    0
`define CFG_MAP_SRAM_BIT  1
`define CFG_ENABLE_RESET  1'b1
`define CFG_MAP_RESET     1'b0
`define PAGE_FLASH_LSB    0
`define PAGE_FLASH_MSB    2
`define PAGE_SRAM_BIT     8
`define FLASH_PAGE_RESET  3'h0
`define SRAM_PAGE_RESET   1'b0
`define STAT_CONFLICT_BIT 0
`define STAT_BUS_EN_BIT   1
`define STAT_ENABLE_BIT   2
`define STAT_MAP_BIT      3
`define STAT_TARGET_LSB   4
`define STAT_TARGET_MSB   9
`define ADDR_TOP_BIT      15
`define ADDR_SUPPORT_BIT  14
`define UART_IDX_MSB      2
`define UART_CHAR_BITS    9
`define UART_FRAME_BITS   4'hB
`define UART_BAUD         19200
`define CLK_HZ            250000000
`endif

/* inc/dsp_map_pkg.sv */
// Types shared by the memory map decoder
package dsp_map_pkg;
    typedef enum logic [5:0] {
        T_NONE    = 6'h01,
        T_FLASH   = 6'h02,
        T_SRAM    = 6'h04,
        T_UART    = 6'h08,
        T_SUPPORT = 6'h10,
        T_SELF    = 6'h20
    } target_type;
endpackage : dsp_map_pkg

/* logic/memory_map_decoder.sv */
// Processor bus decoder with paging and interrupt routing
`timescale 1ns/10ps
`include "dsp_map_params.svh"

// Operation
// - SRAM select: high-active high, low-active low
// - Both byte chips selected together per word
// - Flash selected by driving its select low
// - Only one of flash, SRAM, UART attached
// - Software-writable registers change the mapping
// - Bus enable low disconnects the decoder
// - Support chip drives the bus enable input
// - Program: flash or SRAM; data: SRAM only
// - I/O: decoder, support chip, UART
// - No strobe selects no external device
// - Flash and SRAM never active together
// - Enable first, then write map selection
// - Paging registers swap 64K-word blocks
// - Decoding on 16-bit processor addresses
// - UART eight registers repeat every eight
// - UART select needs I/O strobe, A15 low
// - Four interrupt lines routed, NMI unused
// - UART interrupt forwarded to processor
// - 9-bit character framed at 19200 bps
// - Decoder determines which device is attached
module memory_map_decoder #(
    parameter int BAUD_DIV = `CLK_HZ / `UART_BAUD
) (
    // Clock and reset
    input  wire logic        MCLK,
    input  wire logic        SYS_RST,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Processor bus
    input  wire logic [15:0] DSP_ADDR,
    input  wire logic        PROGRAM_SPACE_STROBE_N,
    input  wire logic        DATA_SPACE_STROBE_N,
    input  wire logic        IO_SPACE_STROBE_N,
    input  wire logic        BUS_ENABLE,
    // Device selects
    output logic             SRAM_SELECT_HIGH_ACTIVE,
    output logic             SRAM_SELECT_LOW_ACTIVE_N,
    output logic             FLASH_SELECT_N,
    output logic             UART_SELECT,
    output logic             SUPPORT_SELECT,
    output logic             DECODER_WINDOW_SELECT,
    output logic             BUS_CONNECTED,
    output logic      [2:0]  FLASH_PAGE,
    output logic             SRAM_PAGE,
    output logic      [2:0]  UART_REG_INDEX,
    // Interrupt sources
    input  wire logic        AUDIO_SAMPLE_TICK,
    input  wire logic        FAST_TICK,
    input  wire logic        KEYPAD_TICK,
    input  wire logic        UART_IRQ_OUT,
    // Processor interrupt lines
    output logic             AUDIO_SAMPLE_IRQ_N,
    output logic             FAST_TICK_IRQ_N,
    output logic             KEYPAD_TIMER_IRQ_N,
    output logic             SERIAL_PORT_IRQ_N,
    output logic             NMI_N,
    // Serial link timing
    output logic             UART_BIT_TICK,
    output logic             UART_FRAME_TICK
);

    localparam int FRAME_BITS = `UART_FRAME_BITS;

    dsp_map_pkg::target_type target;
    dsp_map_pkg::target_type next_target;

    logic        decoder_enable;
    logic        map_sram;
    logic [2:0]  flash_page;
    logic        sram_page;
    logic        strobe_conflict;
    logic        conflict_now;
    logic [1:0]  strobes_low;
    logic        apb_access;
    logic        apb_write;
    logic [31:0] next_rdata;
    logic        next_err;
    logic [13:0] baud_count;
    logic [3:0]  bit_count;

    assign apb_access = PSEL && PENABLE && !PREADY;
    assign apb_write  = apb_access && PWRITE;

    // Count of strobes pulled low
    assign strobes_low = 2'(!PROGRAM_SPACE_STROBE_N)
                       + 2'(!DATA_SPACE_STROBE_N)
                       + 2'(!IO_SPACE_STROBE_N);
    assign conflict_now = strobes_low > 2'h1;

    always_comb
    begin
        next_target = dsp_map_pkg::T_NONE;
        if (BUS_ENABLE && decoder_enable && strobes_low == 2'h1)
        begin
            if (!PROGRAM_SPACE_STROBE_N)
                next_target = map_sram ? dsp_map_pkg::T_SRAM
                                       : dsp_map_pkg::T_FLASH;
            else if (!DATA_SPACE_STROBE_N)
                next_target = dsp_map_pkg::T_SRAM;
            else if (!DSP_ADDR[`ADDR_TOP_BIT])
                next_target = dsp_map_pkg::T_UART;
            else if (DSP_ADDR[`ADDR_SUPPORT_BIT])
                next_target = dsp_map_pkg::T_SUPPORT;
            else
                next_target = dsp_map_pkg::T_SELF;
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
            target <= dsp_map_pkg::T_NONE;
        else
            target <= next_target;
    end

    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            SRAM_SELECT_HIGH_ACTIVE  <= 1'b0;
            SRAM_SELECT_LOW_ACTIVE_N <= 1'b1;
            FLASH_SELECT_N           <= 1'b1;
            UART_SELECT              <= 1'b0;
            SUPPORT_SELECT           <= 1'b0;
            DECODER_WINDOW_SELECT    <= 1'b0;
        end
        else
        begin
            SRAM_SELECT_HIGH_ACTIVE  <= next_target == dsp_map_pkg::T_SRAM;
            SRAM_SELECT_LOW_ACTIVE_N <= next_target != dsp_map_pkg::T_SRAM;
            FLASH_SELECT_N           <= next_target != dsp_map_pkg::T_FLASH;
            UART_SELECT              <= next_target == dsp_map_pkg::T_UART;
            SUPPORT_SELECT <= next_target == dsp_map_pkg::T_SUPPORT;
            DECODER_WINDOW_SELECT <= next_target == dsp_map_pkg::T_SELF;
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
            BUS_CONNECTED <= 1'b0;
        else
            BUS_CONNECTED <= BUS_ENABLE && decoder_enable;
    end

    // register index aliases every eight words
    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
            UART_REG_INDEX <= 3'h0;
        else if (next_target == dsp_map_pkg::T_UART)
            UART_REG_INDEX <= DSP_ADDR[`UART_IDX_MSB:0];
    end

    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            decoder_enable <= `CFG_ENABLE_RESET;
            map_sram       <= `CFG_MAP_RESET;
        end
        else if (apb_write && PADDR == `REG_CONFIG)
        begin
            decoder_enable <= PWDATA[`CFG_ENABLE_BIT];
            if (decoder_enable)
                map_sram <= PWDATA[`CFG_MAP_SRAM_BIT];
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            flash_page <= `FLASH_PAGE_RESET;
            sram_page  <= `SRAM_PAGE_RESET;
        end
        else if (apb_write && PADDR == `REG_PAGE)
        begin
            flash_page <= PWDATA[`PAGE_FLASH_MSB:`PAGE_FLASH_LSB];
            sram_page  <= PWDATA[`PAGE_SRAM_BIT];
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            FLASH_PAGE <= `FLASH_PAGE_RESET;
            SRAM_PAGE  <= `SRAM_PAGE_RESET;
        end
        else
        begin
            FLASH_PAGE <= flash_page;
            SRAM_PAGE  <= sram_page;
        end
    end

    // Sticky strobe clash, set wins over clear
    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
            strobe_conflict <= 1'b0;
        else if (conflict_now)
            strobe_conflict <= 1'b1;
        else if (apb_write && PADDR == `REG_STATUS
                 && PWDATA[`STAT_CONFLICT_BIT])
            strobe_conflict <= 1'b0;
    end

    // Read mux and unmapped answer
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        next_err   = 1'b0;
        unique case (PADDR)
            `REG_CONFIG:
            begin
                next_rdata[`CFG_ENABLE_BIT]   = decoder_enable;
                next_rdata[`CFG_MAP_SRAM_BIT] = map_sram;
            end
            `REG_PAGE:
            begin
                next_rdata[`PAGE_FLASH_MSB:`PAGE_FLASH_LSB] = flash_page;
                next_rdata[`PAGE_SRAM_BIT] = sram_page;
            end
            `REG_STATUS:
            begin
                next_rdata[`STAT_CONFLICT_BIT] = strobe_conflict;
                next_rdata[`STAT_BUS_EN_BIT]   = BUS_ENABLE;
                next_rdata[`STAT_ENABLE_BIT]   = decoder_enable;
                next_rdata[`STAT_MAP_BIT]      = map_sram;
                next_rdata[`STAT_TARGET_MSB:`STAT_TARGET_LSB] = target;
            end
            default:
                next_err = 1'b1;
        endcase
    end

    // One wait state: ready in the second access cycle
    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0000_0000;
        end
        else
        begin
            PREADY  <= apb_access;
            PSLVERR <= apb_access && next_err;
            if (apb_access && !PWRITE)
                PRDATA <= next_rdata;
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            AUDIO_SAMPLE_IRQ_N <= 1'b1;
            FAST_TICK_IRQ_N    <= 1'b1;
            KEYPAD_TIMER_IRQ_N <= 1'b1;
            SERIAL_PORT_IRQ_N  <= 1'b1;
            NMI_N              <= 1'b1;
        end
        else
        begin
            AUDIO_SAMPLE_IRQ_N <= !AUDIO_SAMPLE_TICK;
            FAST_TICK_IRQ_N    <= !FAST_TICK;
            KEYPAD_TIMER_IRQ_N <= !KEYPAD_TICK;
            SERIAL_PORT_IRQ_N  <= !UART_IRQ_OUT;
            NMI_N              <= 1'b1;
        end
    end

    // bit and frame enables for the serial link
    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            baud_count    <= 14'h0000;
            bit_count     <= 4'h0;
            UART_BIT_TICK <= 1'b0;
            UART_FRAME_TICK <= 1'b0;
        end
        else
        begin
            UART_BIT_TICK   <= 1'b0;
            UART_FRAME_TICK <= 1'b0;
            if (baud_count == 14'(BAUD_DIV - 1))
            begin
                baud_count    <= 14'h0000;
                UART_BIT_TICK <= 1'b1;
                if (bit_count == 4'(FRAME_BITS - 1))
                begin
                    bit_count       <= 4'h0;
                    UART_FRAME_TICK <= 1'b1;
                end
                else
                    bit_count <= bit_count + 4'h1;
            end
            else
                baud_count <= baud_count + 14'h0001;
        end
    end

    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (SYS_RST);

    a_sram_pair: assert property (
        SRAM_SELECT_HIGH_ACTIVE == !SRAM_SELECT_LOW_ACTIVE_N)
        else $error("SRAM select pins disagree");
    a_mem_exclusive: assert property (
        !(SRAM_SELECT_HIGH_ACTIVE && !FLASH_SELECT_N))
        else $error("Flash and SRAM active together");
    a_no_strobe: assert property (
        (PROGRAM_SPACE_STROBE_N && DATA_SPACE_STROBE_N
         && IO_SPACE_STROBE_N) |=> FLASH_SELECT_N && !UART_SELECT
         && !SRAM_SELECT_HIGH_ACTIVE && !SUPPORT_SELECT)
        else $error("Device selected without strobe");
    a_bus_detach: assert property (
        !BUS_ENABLE |=> !BUS_CONNECTED && FLASH_SELECT_N
         && !SRAM_SELECT_HIGH_ACTIVE && !UART_SELECT)
        else $error("Decoder attached while bus disabled");
    a_uart_decode: assert property (
        UART_SELECT |-> $past(!IO_SPACE_STROBE_N)
         && !$past(DSP_ADDR[`ADDR_TOP_BIT]))
        else $error("UART selected outside its window");
    a_data_space: assert property (
        (BUS_ENABLE && decoder_enable && !DATA_SPACE_STROBE_N
         && PROGRAM_SPACE_STROBE_N && IO_SPACE_STROBE_N)
        |=> SRAM_SELECT_HIGH_ACTIVE && FLASH_SELECT_N)
        else $error("Data space did not reach SRAM");
    a_prog_flash: assert property (
        (BUS_ENABLE && decoder_enable && !map_sram
         && !PROGRAM_SPACE_STROBE_N && DATA_SPACE_STROBE_N
         && IO_SPACE_STROBE_N) |=> !FLASH_SELECT_N)
        else $error("Flash not mapped in program space");
    a_map_guard: assert property (
        (apb_write && PADDR == `REG_CONFIG && !decoder_enable)
        |=> $stable(map_sram))
        else $error("Map changed while decoder disabled");
    a_page_write: assert property (
        (apb_write && PADDR == `REG_PAGE)
        |=> ##1 FLASH_PAGE
            == $past(PWDATA[`PAGE_FLASH_MSB:`PAGE_FLASH_LSB], 2))
        else $error("Flash page not updated");
    a_uart_irq: assert property (
        UART_IRQ_OUT |=> !SERIAL_PORT_IRQ_N)
        else $error("UART interrupt not forwarded");
    a_apb_ready: assert property (
        (PSEL && PENABLE && !PREADY) |=> PREADY)
        else $error("APB access not answered");
    a_frame_len: assert property (
        UART_FRAME_TICK |-> UART_BIT_TICK && bit_count == 4'h0)
        else $error("Frame tick misplaced");

    c_flash_fetch: cover property (!FLASH_SELECT_N ##1 FLASH_SELECT_N);
    c_sram_remap: cover property ($rose(map_sram));
    c_uart_access: cover property ($rose(UART_SELECT));
    c_conflict: cover property ($rose(strobe_conflict));

endmodule : memory_map_decoder

/* test/dsp_bus_model.sv */
// Processor-side bus partner: space strobes, address, bus enable
`timescale 1ns/10ps

module dsp_bus_model (
    // Requests from the bench
    input  wire logic [1:0]  space,
    input  wire logic [15:0] addr,
    input  wire logic        clash,
    input  wire logic        bus_on,
    // Processor bus
    output logic      [15:0] dsp_addr,
    output logic             ps_n,
    output logic             ds_n,
    output logic             is_n,
    output logic             bus_en
);
    assign ps_n = !(space == 2'h1 || clash);
    assign ds_n = !(space == 2'h2 || clash);
    assign is_n = !(space == 2'h3);
    // Released bus shows the inverted address, not a stale one
    assign dsp_addr = (space != 2'h0) ? addr : ~addr;
    assign bus_en = bus_on;
endmodule : dsp_bus_model

/* test/memory_map_decoder_tb_top.sv */
// Self-checking bench for the processor memory map decoder
`timescale 1ns/10ps

module memory_map_decoder_tb_top;
    logic        mclk = 1'h0;
    logic        sys_rst = 1'h1;
    logic        psel = 1'h0;
    logic        penable = 1'h0;
    logic        pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd, d;
    logic        pready, pslverr, err_bit;
    logic [1:0]  space = 2'h0;
    logic [15:0] addr = 16'h0;
    logic [15:0] dsp_addr;
    logic        clash = 1'h0;
    logic        bus_on = 1'h1;
    logic        ps_n, ds_n, is_n, bus_en, conn, spage, nmi_n;
    logic        sram_hi, sram_lo_n, flash_n, uart_sel, sup_sel, win_sel;
    logic        bit_tick, frame_tick, en, map_sram;
    logic [2:0]  fpage, uidx;
    logic [3:0]  ticks = 4'h0;
    wire  [3:0]  irq_n;
    logic [5:0]  sel;
    int          err_total = 0;
    int          checked = 0;
    int          seed = 4617;
    int          cycles = 0;
    int          nb, nf;

    assign sel = {sram_hi, sram_lo_n, flash_n, uart_sel, sup_sel, win_sel};

    always #2 mclk = ~mclk;

    dsp_bus_model partner (.space(space), .addr(addr), .clash(clash),
        .bus_on(bus_on), .dsp_addr(dsp_addr), .ps_n(ps_n), .ds_n(ds_n),
        .is_n(is_n), .bus_en(bus_en));

    memory_map_decoder #(.BAUD_DIV(8)) DUT (.MCLK(mclk), .SYS_RST(sys_rst),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .DSP_ADDR(dsp_addr),
        .PROGRAM_SPACE_STROBE_N(ps_n), .DATA_SPACE_STROBE_N(ds_n),
        .IO_SPACE_STROBE_N(is_n), .BUS_ENABLE(bus_en),
        .SRAM_SELECT_HIGH_ACTIVE(sram_hi),
        .SRAM_SELECT_LOW_ACTIVE_N(sram_lo_n), .FLASH_SELECT_N(flash_n),
        .UART_SELECT(uart_sel), .SUPPORT_SELECT(sup_sel),
        .DECODER_WINDOW_SELECT(win_sel), .BUS_CONNECTED(conn),
        .FLASH_PAGE(fpage), .SRAM_PAGE(spage), .UART_REG_INDEX(uidx),
        .AUDIO_SAMPLE_TICK(ticks[3]), .FAST_TICK(ticks[2]),
        .KEYPAD_TICK(ticks[1]), .UART_IRQ_OUT(ticks[0]),
        .AUDIO_SAMPLE_IRQ_N(irq_n[3]), .FAST_TICK_IRQ_N(irq_n[2]),
        .KEYPAD_TIMER_IRQ_N(irq_n[1]), .SERIAL_PORT_IRQ_N(irq_n[0]),
        .NMI_N(nmi_n), .UART_BIT_TICK(bit_tick),
        .UART_FRAME_TICK(frame_tick));

    task automatic test_done;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen,
                     exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd);
        @(posedge mclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'h1;
        do
        begin
            @(posedge mclk);
        end
        while (pready !== 1'h1);
        rd = prdata;
        err_bit = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task automatic cfg_write(input logic [31:0] wd);
        apb(1'h1, 12'h000, wd);
        if (en)
            map_sram = wd[1];
        en = wd[0];
    endtask : cfg_write

    // Expected selects {sram hi, sram lo_n, flash_n, uart, support, self}
    function automatic logic [5:0] exp_sel(input logic [1:0] sp,
        input logic [15:0] a, input logic cl, input logic on);
        if (!on || !en || cl || sp == 2'h0)
            return 6'h18;
        if (sp == 2'h1)
            return map_sram ? 6'h28 : 6'h10;
        if (sp == 2'h2)
            return 6'h28;
        if (!a[15])
            return 6'h1C;
        return a[14] ? 6'h1A : 6'h19;
    endfunction : exp_sel

    task automatic bus_op(input logic [1:0] sp, input logic [15:0] a,
                          input logic cl, input logic on);
        logic [5:0] e;
        @(posedge mclk);
        space <= sp;
        addr <= a;
        clash <= cl;
        bus_on <= on;
        @(posedge mclk);
        #1;
        e = exp_sel(sp, a, cl, on);
        check(sel, e);
        check(conn, on & en);
        if (e == 6'h1C)
            check(uidx, a[2:0]);
    endtask : bus_op

    task automatic sweep(input logic on);
        logic [15:0] a;
        for (int s = 0; s < 4; s++)
            for (int h = 0; h < 4; h++)
            begin
                a = $random(seed);
                a[15:14] = h[1:0];
                bus_op(s[1:0], a, 1'h0, on);
            end
    endtask : sweep

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            err_total++;
            test_done;
        end
    end

    initial
    begin
        en = 1'h1;
        map_sram = 1'h0;
        repeat (4) @(posedge mclk);
        sys_rst <= 1'h0;
        #1;
        check({sel, fpage, spage, irq_n, nmi_n}, 15'h301F);
        apb(1'h0, 12'h000, 32'h0);
        check(rd, 32'h1);
        apb(1'h0, 12'h00C, 32'h0);
        check(err_bit, 1'h1);
        check(rd, 32'h0);
        $display("test reset done");
        sweep(1'h1);
        $display("test flash map done");
        cfg_write(32'h3);
        sweep(1'h1);
        sweep(1'h0);
        $display("test sram map done");
        cfg_write(32'h0);
        cfg_write(32'h2);
        apb(1'h0, 12'h000, 32'h0);
        check(rd, {30'h0, map_sram, en});
        sweep(1'h1);
        cfg_write(32'h1);
        apb(1'h0, 12'h000, 32'h0);
        check(rd, {30'h0, map_sram, en});
        $display("test enable order done");
        bus_op(2'h0, 16'h1234, 1'h1, 1'h1);
        bus_op(2'h0, 16'h0, 1'h0, 1'h1);
        apb(1'h0, 12'h008, 32'h0);
        check(rd[9:0], {dsp_map_pkg::T_NONE, map_sram, en, 2'h3});
        apb(1'h1, 12'h008, 32'h1);
        apb(1'h0, 12'h008, 32'h0);
        check(rd[0], 1'h0);
        $display("test strobe clash done");
        repeat (3)
        begin
            d = $random(seed);
            apb(1'h1, 12'h004, d);
            repeat (3) @(posedge mclk);
            #1;
            check({fpage, spage}, {d[2:0], d[8]});
            apb(1'h0, 12'h004, 32'h0);
            check(rd, d & 32'h107);
        end
        $display("test paging done");
        // Reset in mid-run restores the boot map
        @(posedge mclk);
        sys_rst <= 1'h1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'h0;
        en = 1'h1;
        map_sram = 1'h0;
        apb(1'h0, 12'h000, 32'h0);
        check(rd, 32'h1);
        check({fpage, spage}, 4'h0);
        $display("test mid reset done");
        bus_op(2'h1, 16'h0100, 1'h0, 1'h1);
        bus_op(2'h0, 16'h0100, 1'h0, 1'h1);
        cfg_write(32'h3);
        bus_op(2'h1, 16'h0100, 1'h0, 1'h1);
        bus_op(2'h2, 16'h0100, 1'h0, 1'h1);
        $display("test code copy done");
        repeat (8)
        begin
            d = $random(seed);
            @(posedge mclk);
            ticks <= d[3:0];
            @(posedge mclk);
            #1;
            check({irq_n, nmi_n}, {~d[3:0], 1'h1});
        end
        @(posedge mclk);
        ticks <= 4'h1;
        bus_op(2'h3, 16'h0005, 1'h0, 1'h1);
        check(irq_n[0], 1'h0);
        @(posedge mclk);
        ticks <= 4'h0;
        $display("test interrupts done");
        nb = 0;
        nf = 0;
        repeat (176)
        begin
            @(posedge mclk);
            nb += bit_tick;
            nf += frame_tick;
        end
        check(nb, 22);
        check(nf, 2);
        $display("test serial timing done");
        test_done;
    end
endmodule : memory_map_decoder_tb_top
